// *** dv/dms_host.sv ***
// behavioural host controller: discrete mode, source and trigger inputs
module dms_host
	import dms_pkg::*;
(
	input wire logic sys_clk,
	output logic position_torque_select_input,
	output logic velocity_torque_select_input,
	output logic torque_source_select_bit0,
	output logic torque_source_select_bit1,
	output logic [SRC_SEL_W-1:0] velocity_source_select,
	output logic [POS_SEL_W-1:0] position_select,
	output logic command_trigger,
	output logic pulse_step,
	output logic pulse_dir
);
	timeunit 1ns;
	timeprecision 1ps;

	// all lines idle low until the first command
	initial begin
		position_torque_select_input = 1'b0;
		velocity_torque_select_input = 1'b0;
		{torque_source_select_bit1, torque_source_select_bit0} = 2'h0;
		velocity_source_select = 2'h0;
		position_select = 4'h0;
		command_trigger = 1'b0;
		pulse_step = 1'b0;
		pulse_dir = 1'b0;
	end

	// levels change just after an edge and then stand
	task automatic sel(input logic pt, vt, input logic [1:0] tc, vs);
		@(posedge sys_clk);
		#1;
		position_torque_select_input = pt;
		velocity_torque_select_input = vt;
		{torque_source_select_bit1, torque_source_select_bit0} = tc;
		velocity_source_select = vs;
	endtask

	// select settles well ahead of the trigger edge, then turns to junk
	task automatic fire(input logic [3:0] s);
		@(posedge sys_clk);
		#1;
		position_select = s;
		repeat (3) @(posedge sys_clk);
		#1;
		command_trigger = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		command_trigger = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		position_select = ~s; // don't-care after use, so not left stale
	endtask

	// one step, three clocks high and low so the synchroniser sees it
	task automatic step(input logic d);
		@(posedge sys_clk);
		#1;
		pulse_dir = d;
		repeat (3) @(posedge sys_clk);
		#1;
		pulse_step = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		pulse_step = 1'b0;
	endtask
endmodule

// *** dv/tb.sv ***
module tb
	import dms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	dms_dual_e dual_mode_sel = PRESET_POSITION_TORQUE_DUAL_MODE;
	logic zero_default_torque_mode = 1'b0;
	logic mode_select_assigned = 1'b1;
	logic velocity_select_assigned = 1'b1;
	logic torque_select_assigned = 1'b1;
	logic [15:0] limit_config = 16'h000a;
	logic position_torque_select_input, velocity_torque_select_input;
	logic torque_source_select_bit0, torque_source_select_bit1;
	logic [1:0] velocity_source_select;
	logic [3:0] position_select;
	logic command_trigger, pulse_step, pulse_dir;
	logic signed [31:0] pos_preset [16];
	logic signed [15:0] torque_preset [3];
	logic signed [15:0] velocity_preset [3];
	logic signed [15:0] analog_torque = 16'sh0444;
	logic signed [15:0] analog_velocity = 16'sh0500;
	logic [15:0] max_velocity_limit = 16'h0800;
	dms_mode_e mode_r;
	logic motor_hold_r, pos_valid_r, vel_limit_on_r, torque_limit_on_r;
	logic signed [31:0] pos_cmd_r;
	logic signed [15:0] torque_cmd_r, vel_cmd_r, e;
	logic [15:0] vel_limit_r, torque_limit_r;
	int fails = 0;
	int cmp_count = 0;

	dms_host dms_host_i (.sys_clk, .position_torque_select_input,
		.velocity_torque_select_input, .torque_source_select_bit0,
		.torque_source_select_bit1, .velocity_source_select,
		.position_select, .command_trigger, .pulse_step, .pulse_dir);

	dms_selector dms_selector_i (.sys_clk, .reset, .dual_mode_sel,
		.zero_default_torque_mode, .mode_select_assigned,
		.velocity_select_assigned, .torque_select_assigned, .limit_config,
		.position_torque_select_input, .velocity_torque_select_input,
		.torque_source_select_bit0, .torque_source_select_bit1,
		.velocity_source_select, .position_select, .command_trigger,
		.pulse_step, .pulse_dir, .pos_preset, .torque_preset,
		.velocity_preset, .analog_torque, .analog_velocity,
		.max_velocity_limit, .mode_r, .motor_hold_r, .pos_valid_r,
		.pos_cmd_r, .torque_cmd_r, .vel_cmd_r, .vel_limit_r,
		.vel_limit_on_r, .torque_limit_r, .torque_limit_on_r);

	// 200 mhz clock
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// distinct table contents so a wrong index shows up
	initial begin
		for (int i = 0; i < 16; i++) begin
			pos_preset[i] = 32'sh10000000 + i;
		end
		torque_preset = '{16'sh0100, 16'sh0200, 16'sh0300};
		velocity_preset = '{16'sh0111, 16'sh0222, 16'sh0333};
	end

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic rst();
		@(posedge sys_clk);
		#1;
		reset = 1'b1;
		wt(8);
		reset = 1'b0;
	endtask

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge sys_clk);
		fails++;
		close_out();
	end

	initial begin
		rst();
		`CHK("mode", DMS_MODE_TORQUE, mode_r)
		`CHK("tlim", 16'h7fff, torque_limit_r)
		// preset/torque, torque side: every source code, trigger ignored
		for (int c = 0; c < 4; c++) begin
			dms_host_i.sel(1'b0, 1'b0, c[1:0], 2'h0);
			wt(4);
			e = (c == 0) ? analog_torque : torque_preset[c-1];
			`CHK("tcmd", e, torque_cmd_r)
		end
		dms_host_i.fire(4'h5);
		wt(4);
		`CHK("valid", 1'b0, pos_valid_r)
		// position side: held until a trigger edge picks an entry
		dms_host_i.sel(1'b1, 1'b0, 2'h2, 2'h0);
		wt(2);
		`CHK("mode", DMS_MODE_TORQUE, mode_r)
		wt(2);
		`CHK("mode", DMS_MODE_POSITION, mode_r)
		`CHK("hold", 1'b1, motor_hold_r)
		`CHK("valid", 1'b0, pos_valid_r)
		`CHK("tlim", torque_preset[1], torque_limit_r)
		`CHK("vlim", 16'h0800, vel_limit_r)
		// no torque select inputs wired: the analog input sets the limit
		torque_select_assigned = 1'b0;
		wt(4);
		`CHK("tlim", analog_torque, torque_limit_r)
		torque_select_assigned = 1'b1;
		dms_host_i.fire(4'hf);
		wt(4);
		`CHK("pcmd", pos_preset[15], pos_cmd_r)
		`CHK("valid", 1'b1, pos_valid_r)
		`CHK("hold", 1'b0, motor_hold_r)
		dms_host_i.sel(1'b0, 1'b0, 2'h2, 2'h0);
		wt(4);
		`CHK("mode", DMS_MODE_TORQUE, mode_r)
		`CHK("valid", 1'b0, pos_valid_r)
		`CHK("tlon", 1'b0, torque_limit_on_r)
		// unwired mode input keeps the default mode
		mode_select_assigned = 1'b0;
		dms_host_i.sel(1'b1, 1'b0, 2'h2, 2'h0);
		wt(4);
		`CHK("mode", DMS_MODE_TORQUE, mode_r)
		mode_select_assigned = 1'b1;
		// pulse/torque: three up, one down, no trigger needed
		rst();
		dual_mode_sel = PULSE_POSITION_TORQUE_DUAL_MODE;
		dms_host_i.sel(1'b1, 1'b0, 2'h0, 2'h0);
		wt(4);
		repeat (3) dms_host_i.step(1'b0);
		dms_host_i.step(1'b1);
		wt(4);
		`CHK("pcmd", 32'sd2, pos_cmd_r)
		// velocity/torque, torque side with velocity limit
		dual_mode_sel = VELOCITY_TORQUE_DUAL_MODE;
		zero_default_torque_mode = 1'b1;
		limit_config = 16'd21;
		velocity_select_assigned = 1'b0;
		dms_host_i.sel(1'b0, 1'b1, 2'h0, 2'h3);
		wt(4);
		`CHK("mode", DMS_MODE_TORQUE, mode_r)
		`CHK("tcmd", 16'sh0000, torque_cmd_r)
		`CHK("vlim", analog_velocity, vel_limit_r)
		velocity_select_assigned = 1'b1;
		wt(4);
		`CHK("vlim", velocity_preset[2], vel_limit_r)
		`CHK("vlon", 1'b1, vel_limit_on_r)
		// velocity side: analog above the maximum is clamped
		analog_velocity = 16'sh1000;
		for (int v = 0; v < 4; v++) begin
			dms_host_i.sel(1'b0, 1'b0, 2'h0, v[1:0]);
			wt(4);
			e = (v == 0) ? 16'sh0800 : velocity_preset[v-1];
			`CHK("mode", DMS_MODE_VELOCITY, mode_r)
			`CHK("vcmd", e, vel_cmd_r)
		end
		`CHK("tlon", 1'b0, torque_limit_on_r)
		limit_config = 16'd10;
		wt(4);
		`CHK("tlim", analog_torque, torque_limit_r)
		dms_host_i.sel(1'b0, 1'b1, 2'h0, 2'h0);
		wt(4);
		`CHK("mode", DMS_MODE_TORQUE, mode_r)
		mode_select_assigned = 1'b0;
		wt(4);
		`CHK("mode", DMS_MODE_VELOCITY, mode_r)
		close_out();
	end
endmodule

// *** hdl/dms_pkg.sv ***
package dms_pkg;
	// dual control mode chosen by configuration
	typedef enum logic [1:0] {
		PULSE_POSITION_TORQUE_DUAL_MODE,
		PRESET_POSITION_TORQUE_DUAL_MODE,
		VELOCITY_TORQUE_DUAL_MODE
	} dms_dual_e;

	// control mode that is running right now
	typedef enum logic [1:0] {
		DMS_MODE_TORQUE,
		DMS_MODE_POSITION,
		DMS_MODE_VELOCITY
	} dms_mode_e;

	// preset table sizes
	localparam int POS_PRESET_N = 16;
	localparam int POS_SEL_W = 4;
	localparam int SRC_PRESET_N = 3;
	localparam int SRC_SEL_W = 2;

	// source select code that means the analog input (or zero)
	localparam logic [SRC_SEL_W-1:0] SRC_SEL_ANALOG = 2'h0;

	// limit configuration: decimal digits, a digit of one enables
	localparam logic [15:0] LIM_DEC_BASE = 16'h000a;
	localparam logic [15:0] LIM_DIGIT_ON = 16'h0001;

	// synchroniser depth
	localparam int SYNC_STAGES = 2;
endpackage

// *** hdl/dms_selector.sv ***
// Contract
// - preset/torque: position from 16-entry preset table
// - pulse/torque: position from external pulses
// - torque from analog or three torque presets
// - select off: torque mode, trigger ignored
// - entering preset position: hold until trigger
// - trigger edge latches selected preset entry
// - pulse position responds to pulses immediately
// - select off returns to torque at once
// - velocity from analog or three velocity presets
// - velocity/torque select on: torque mode
// - select off: velocity mode, follow at once
// - select on again: torque without delay
// - velocity always clamped to maximum limit
// - velocity limit: torque mode, presets or analog
// - velocity limit enabled when digit0 is one
// - torque limit: position/velocity, presets or analog
// - torque limit enabled when digit1 is one
// - both selects off: zero or analog torque
// - no mode input assigned: torque mode, or velocity mode in velocity/torque
// - velocity/torque: low velocity, high torque
module dms_selector
	import dms_pkg::*;
#(
	parameter int POS_W = 32,
	parameter int CMD_W = 16,
	parameter logic [CMD_W-1:0] TORQUE_FULL_SCALE = 16'h7fff
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire dms_dual_e dual_mode_sel,
	input wire logic zero_default_torque_mode,
	input wire logic mode_select_assigned,
	input wire logic velocity_select_assigned,
	input wire logic torque_select_assigned,
	input wire logic [15:0] limit_config,
	input wire logic position_torque_select_input,
	input wire logic velocity_torque_select_input,
	input wire logic torque_source_select_bit0,
	input wire logic torque_source_select_bit1,
	input wire logic [SRC_SEL_W-1:0] velocity_source_select,
	input wire logic [POS_SEL_W-1:0] position_select,
	input wire logic command_trigger,
	input wire logic pulse_step,
	input wire logic pulse_dir,
	input wire logic signed [POS_W-1:0] pos_preset [POS_PRESET_N],
	input wire logic signed [CMD_W-1:0] torque_preset [SRC_PRESET_N],
	input wire logic signed [CMD_W-1:0] velocity_preset [SRC_PRESET_N],
	input wire logic signed [CMD_W-1:0] analog_torque,
	input wire logic signed [CMD_W-1:0] analog_velocity,
	input wire logic [CMD_W-1:0] max_velocity_limit,
	output dms_mode_e mode_r,
	output logic motor_hold_r,
	output logic pos_valid_r,
	output logic signed [POS_W-1:0] pos_cmd_r,
	output logic signed [CMD_W-1:0] torque_cmd_r,
	output logic signed [CMD_W-1:0] vel_cmd_r,
	output logic [CMD_W-1:0] vel_limit_r,
	output logic vel_limit_on_r,
	output logic [CMD_W-1:0] torque_limit_r,
	output logic torque_limit_on_r
);
	localparam int SYNC_W = 2 * SRC_SEL_W + POS_SEL_W + 5;

	logic [SYNC_W-1:0] raw_bus;
	logic [SYNC_W-1:0] sync_bus;
	logic position_torque_select_input_s, velocity_torque_select_input_s, trig_s, step_s, dir_s;
	logic [SRC_SEL_W-1:0] tsel_s, vsel_s;
	logic [POS_SEL_W-1:0] psel_s;
	logic trig_d_r, step_d_r;
	logic trig_rise, step_rise;
	dms_mode_e mode_nxt;
	logic signed [POS_W-1:0] preset_pick;
	logic signed [CMD_W-1:0] torque_sel, vel_sel, vel_clamped;
	logic [CMD_W-1:0] tlim_src, vlim_src, vlim_sel;
	logic vlim_en, tlim_en;

	// magnitude of a signed command, saturating the most negative code
	function automatic logic [CMD_W-1:0] mag(input logic signed [CMD_W-1:0] v);
		logic [CMD_W-1:0] m;
		m = v[CMD_W-1] ? CMD_W'(-v) : CMD_W'(v);
		if (m[CMD_W-1])
			m = {1'b0, {(CMD_W-1){1'b1}}};
		return m;
	endfunction

	// all discrete inputs pass one synchroniser as a group
	assign raw_bus = {position_torque_select_input,
		velocity_torque_select_input, command_trigger, pulse_step, pulse_dir,
		torque_source_select_bit1, torque_source_select_bit0,
		velocity_source_select, position_select};

	dms_sync #(.W(SYNC_W)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.d(raw_bus),
		.q(sync_bus)
	);

	assign {position_torque_select_input_s, velocity_torque_select_input_s, trig_s, step_s, dir_s, tsel_s, vsel_s,
		psel_s} = sync_bus;

	// edge detectors look only at synchronised levels
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trig_d_r <= 1'b0;
			step_d_r <= 1'b0;
		end else begin
			trig_d_r <= trig_s;
			step_d_r <= step_s;
		end
	end

	assign trig_rise = trig_s && !trig_d_r;
	assign step_rise = step_s && !step_d_r;

	// mode decode; an unassigned mode input gives torque mode, or velocity mode in velocity/torque
	always_comb begin
		mode_nxt = DMS_MODE_TORQUE;
		case (dual_mode_sel)
			PULSE_POSITION_TORQUE_DUAL_MODE,
			PRESET_POSITION_TORQUE_DUAL_MODE: begin
				if (mode_select_assigned && position_torque_select_input_s)
					mode_nxt = DMS_MODE_POSITION;
				else
					mode_nxt = DMS_MODE_TORQUE;
			end
			VELOCITY_TORQUE_DUAL_MODE: begin
				if (mode_select_assigned && velocity_torque_select_input_s)
					mode_nxt = DMS_MODE_TORQUE;
				else
					mode_nxt = DMS_MODE_VELOCITY;
			end
			default: mode_nxt = DMS_MODE_TORQUE;
		endcase
	end

	// mode switches take effect on the next edge, no extra delay
	always_ff @(posedge sys_clk) begin
		if (reset)
			mode_r <= DMS_MODE_TORQUE;
		else
			mode_r <= mode_nxt;
	end

	assign preset_pick = pos_preset[psel_s];

	// position command: preset latched on trigger, or pulse counter
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pos_cmd_r <= '0;
			pos_valid_r <= 1'b0;
		end else if (dual_mode_sel == PRESET_POSITION_TORQUE_DUAL_MODE) begin
			if (mode_nxt != DMS_MODE_POSITION) begin
				pos_valid_r <= 1'b0;
			end else if (mode_r != DMS_MODE_POSITION) begin
				pos_valid_r <= 1'b0;
			end else if (trig_rise) begin
				pos_cmd_r <= preset_pick;
				pos_valid_r <= 1'b1;
			end
		end else if (dual_mode_sel == PULSE_POSITION_TORQUE_DUAL_MODE) begin
			pos_valid_r <= (mode_nxt == DMS_MODE_POSITION);
			if (mode_r == DMS_MODE_POSITION && step_rise) begin
				if (dir_s)
					pos_cmd_r <= pos_cmd_r - POS_W'(1);
				else
					pos_cmd_r <= pos_cmd_r + POS_W'(1);
			end
		end else begin
			pos_valid_r <= 1'b0;
		end
	end

	// motor is held while the preset position is still undetermined
	always_ff @(posedge sys_clk) begin
		if (reset)
			motor_hold_r <= 1'b0;
		else if (dual_mode_sel == PRESET_POSITION_TORQUE_DUAL_MODE &&
			mode_nxt == DMS_MODE_POSITION)
			motor_hold_r <= !(mode_r == DMS_MODE_POSITION &&
				(trig_rise || pos_valid_r));
		else
			motor_hold_r <= 1'b0;
	end

	// torque source: code zero is analog, or zero torque when configured
	always_comb begin
		if (tsel_s == SRC_SEL_ANALOG)
			torque_sel = zero_default_torque_mode ? '0 : analog_torque;
		else
			torque_sel = torque_preset[tsel_s - 2'h1];
	end

	// velocity source: code zero is analog, others pick a preset
	always_comb begin
		if (vsel_s == SRC_SEL_ANALOG)
			vel_sel = analog_velocity;
		else
			vel_sel = velocity_preset[vsel_s - 2'h1];
	end

	// clamp to the maximum velocity, keeping the sign
	always_comb begin
		if (mag(vel_sel) > max_velocity_limit)
			vel_clamped = vel_sel[CMD_W-1] ? -$signed(max_velocity_limit)
				: $signed(max_velocity_limit);
		else
			vel_clamped = vel_sel;
	end

	// command outputs; inactive loops receive zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			torque_cmd_r <= '0;
			vel_cmd_r <= '0;
		end else begin
			torque_cmd_r <= (mode_nxt == DMS_MODE_TORQUE) ? torque_sel : '0;
			vel_cmd_r <= (mode_nxt == DMS_MODE_VELOCITY) ? vel_clamped : '0;
		end
	end

	// limit enables come from the two low decimal digits of the config
	assign vlim_en = (limit_config % LIM_DEC_BASE) == LIM_DIGIT_ON;
	assign tlim_en = ((limit_config / LIM_DEC_BASE) % LIM_DEC_BASE)
		== LIM_DIGIT_ON;

	// without select inputs wired, the analog input is the limit source
	assign vlim_src = (!velocity_select_assigned || vsel_s == SRC_SEL_ANALOG)
		? mag(analog_velocity) : mag(vel_sel);
	assign tlim_src = (!torque_select_assigned || tsel_s == SRC_SEL_ANALOG)
		? mag(analog_torque) : mag(torque_preset[tsel_s - 2'h1]);
	assign vlim_sel = (vlim_src < max_velocity_limit) ? vlim_src
		: max_velocity_limit;

	// velocity limit in torque mode only, never above the maximum
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vel_limit_r <= '0;
			vel_limit_on_r <= 1'b0;
		end else if (vlim_en && mode_nxt == DMS_MODE_TORQUE) begin
			vel_limit_r <= vlim_sel;
			vel_limit_on_r <= 1'b1;
		end else begin
			vel_limit_r <= max_velocity_limit;
			vel_limit_on_r <= 1'b0;
		end
	end

	// torque limit in position and velocity modes only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			torque_limit_r <= TORQUE_FULL_SCALE;
			torque_limit_on_r <= 1'b0;
		end else if (tlim_en && mode_nxt != DMS_MODE_TORQUE) begin
			torque_limit_r <= tlim_src;
			torque_limit_on_r <= 1'b1;
		end else begin
			torque_limit_r <= TORQUE_FULL_SCALE;
			torque_limit_on_r <= 1'b0;
		end
	end

	// checks
	sequence s_in_preset_pos;
		dual_mode_sel == PRESET_POSITION_TORQUE_DUAL_MODE &&
			mode_r == DMS_MODE_POSITION && mode_nxt == DMS_MODE_POSITION;
	endsequence

	sequence s_latched;
		pos_valid_r && !motor_hold_r;
	endsequence

	property p_trig_latch;
		@(posedge sys_clk) disable iff (reset)
		s_in_preset_pos and trig_rise |=> s_latched ##0
			(pos_cmd_r == $past(preset_pick));
	endproperty
	a_trig_latch: assert property (p_trig_latch)
		else $error("trigger did not latch the selected preset");

	property p_enter_hold;
		@(posedge sys_clk) disable iff (reset)
		dual_mode_sel == PRESET_POSITION_TORQUE_DUAL_MODE &&
			mode_r != DMS_MODE_POSITION && mode_nxt == DMS_MODE_POSITION
			|=> motor_hold_r && !pos_valid_r;
	endproperty
	a_enter_hold: assert property (p_enter_hold)
		else $error("position entry did not hold the motor");

	property p_pos_to_torque;
		@(posedge sys_clk) disable iff (reset)
		dual_mode_sel != VELOCITY_TORQUE_DUAL_MODE && !position_torque_select_input_s
			|=> mode_r == DMS_MODE_TORQUE && !pos_valid_r;
	endproperty
	a_pos_to_torque: assert property (p_pos_to_torque)
		else $error("position select off did not give torque mode");

	property p_vt_torque;
		@(posedge sys_clk) disable iff (reset)
		dual_mode_sel == VELOCITY_TORQUE_DUAL_MODE && mode_select_assigned &&
			velocity_torque_select_input_s |=> mode_r == DMS_MODE_TORQUE && vel_cmd_r == '0;
	endproperty
	a_vt_torque: assert property (p_vt_torque)
		else $error("velocity/torque select on did not give torque");

	property p_vt_velocity;
		@(posedge sys_clk) disable iff (reset)
		dual_mode_sel == VELOCITY_TORQUE_DUAL_MODE && !velocity_torque_select_input_s
			|=> mode_r == DMS_MODE_VELOCITY && torque_cmd_r == '0;
	endproperty
	a_vt_velocity: assert property (p_vt_velocity)
		else $error("velocity/torque select off did not give velocity");

	property p_default_mode;
		@(posedge sys_clk) disable iff (reset)
		!mode_select_assigned && dual_mode_sel !=
			VELOCITY_TORQUE_DUAL_MODE |=> mode_r == DMS_MODE_TORQUE;
	endproperty
	a_default_mode: assert property (p_default_mode)
		else $error("unassigned mode input left default mode");

	property p_zero_torque;
		@(posedge sys_clk) disable iff (reset)
		mode_nxt == DMS_MODE_TORQUE && zero_default_torque_mode &&
			tsel_s == SRC_SEL_ANALOG |=> torque_cmd_r == '0;
	endproperty
	a_zero_torque: assert property (p_zero_torque)
		else $error("zero default torque mode gave nonzero torque");

	property p_pulse_count;
		@(posedge sys_clk) disable iff (reset)
		dual_mode_sel == PULSE_POSITION_TORQUE_DUAL_MODE &&
			mode_r == DMS_MODE_POSITION && step_rise && !dir_s
			|=> pos_cmd_r == $past(pos_cmd_r) + POS_W'(1);
	endproperty
	a_pulse_count: assert property (p_pulse_count)
		else $error("forward pulse did not advance position");

	property p_vel_clamp;
		@(posedge sys_clk) disable iff (reset)
		##1 mag(vel_cmd_r) <= $past(max_velocity_limit);
	endproperty
	a_vel_clamp: assert property (p_vel_clamp)
		else $error("velocity command above maximum limit");

	property p_vlim_gate;
		@(posedge sys_clk) disable iff (reset)
		!vlim_en |=> !vel_limit_on_r && vel_limit_r ==
			$past(max_velocity_limit);
	endproperty
	a_vlim_gate: assert property (p_vlim_gate)
		else $error("velocity limit active while disabled");

	property p_tlim_gate;
		@(posedge sys_clk) disable iff (reset)
		tlim_en && mode_nxt == DMS_MODE_VELOCITY |=> torque_limit_on_r;
	endproperty
	a_tlim_gate: assert property (p_tlim_gate)
		else $error("torque limit not active in velocity mode");
endmodule

// *** hdl/dms_sync.sv ***
// two-flop synchroniser for a group of level inputs
module dms_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
